// file: rtl/phase_shift_defines.svh
`ifndef PHASE_SHIFT_DEFINES_SVH
`define PHASE_SHIFT_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SYNTH0_DIVC_SHIFT_IDX 8'hBF
`define SYNTH0_DIVD_SHIFT_IDX 8'hC1
`define OSC_SOURCE_SELECT_IDX 8'hC3
`define SILICON_REVISION_IDX 8'hC6
`define SYNTH1_DIVC_SHIFT_IDX 8'hC7
`define SYNTH1_DIVD_SHIFT_IDX 8'hC9
`define SYNTH2_DIVA_SHIFT_IDX 8'hCB

// ****************************************************************
// Field positions
// ****************************************************************
`define COARSE_LSB 0
`define COARSE_MSB 12
`define QUAD_LSB 13
`define QUAD_MSB 15
`define OSC_SOURCE_BIT 0

// ****************************************************************
// Reset values and bus geometry
// ****************************************************************
`define SHIFT_RESET 16'h0000
`define OSC_SOURCE_RESET 8'h00
`define SHIFT_PAIRS 5
`define BUS_ADDR_W 10
`define BUS_DATA_W 32

`endif

// file: rtl/phase_shift_pkg.sv
package phase_shift_pkg;

  // Settings handed to one post divider and all clocks it produces.
  typedef struct packed {
    logic [12:0] coarse;
    logic [2:0] quad_code;
    logic signed [3:0] quad_steps;
  } shift_cfg_s;

  // Decoded view of a register index that hits a shift pair.
  typedef struct packed {
    logic hit;
    logic hi;
    logic [2:0] slot;
  } slot_sel_s;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;

endpackage : phase_shift_pkg

// file: rtl/shift_pair_reg.sv
`timescale 1ns/1ns
`include "phase_shift_defines.svh"

module shift_pair_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Byte writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wr_byte,
  // Committed setting
  output logic [15:0] value
);
  import phase_shift_pkg::*;

  logic [7:0] staged_lo;

  // The low byte waits here until the high byte completes the value.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      staged_lo <= 8'h00;
    end else if (wr_lo) begin
      staged_lo <= wr_byte;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value <= `SHIFT_RESET;
    end else if (wr_hi) begin
      value <= {wr_byte, staged_lo};
    end
  end

  property p_commit_only_on_hi;
    @(posedge clk) disable iff (sys_rst)
    !wr_hi |=> $stable(value);
  endproperty
  a_commit_only_on_hi: assert property (p_commit_only_on_hi)
    else $error("shift value changed without a high byte write");

  property p_commit_whole;
    @(posedge clk) disable iff (sys_rst)
    wr_lo ##3 wr_hi |=>
      value == {$past(wr_byte), $past(wr_byte, 4)};
  endproperty
  a_commit_whole: assert property (p_commit_whole)
    else $error("committed value does not join both written bytes");

endmodule : shift_pair_reg

// file: rtl/shift_cfg_out.sv
`timescale 1ns/1ns
`include "phase_shift_defines.svh"

module shift_cfg_out (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Committed register pair
  input wire logic [15:0] value,
  // Settings to the post divider
  output phase_shift_pkg::shift_cfg_s cfg
);
  import phase_shift_pkg::*;

  // Steps of 45 degrees, negative meaning a lag.
  function automatic logic signed [3:0] quad_steps_of(
    input logic [2:0] code
  );
    case (code)
      3'h0: quad_steps_of = 4'sh0;
      3'h1: quad_steps_of = -4'sh1;
      3'h2: quad_steps_of = -4'sh2;
      3'h3: quad_steps_of = -4'sh3;
      3'h4: quad_steps_of = -4'sh4;
      3'h5: quad_steps_of = 4'sh3;
      3'h6: quad_steps_of = 4'sh2;
      3'h7: quad_steps_of = 4'sh1;
      default: quad_steps_of = 4'sh0;
    endcase
  endfunction : quad_steps_of

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= '0;
    end else begin
      cfg.coarse <= value[`COARSE_MSB:`COARSE_LSB];
      cfg.quad_code <= value[`QUAD_MSB:`QUAD_LSB];
      cfg.quad_steps <= quad_steps_of(value[`QUAD_MSB:`QUAD_LSB]);
    end
  end

  property p_coarse_signed;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> $signed(cfg.coarse) == $signed($past(value[12:0]));
  endproperty
  a_coarse_signed: assert property (p_coarse_signed)
    else $error("coarse shift is not the low thirteen bits");

  property p_coarse_zero;
    @(posedge clk) disable iff (sys_rst)
    value[12:0] == 13'h0000 |=> cfg.coarse == 13'h0000;
  endproperty
  a_coarse_zero: assert property (p_coarse_zero)
    else $error("zero coarse shift not passed as no shift");

  property p_quad_lag;
    @(posedge clk) disable iff (sys_rst)
    value[15] == 1'b0 |=>
      cfg.quad_steps == -$signed({2'b00, $past(value[14:13])});
  endproperty
  a_quad_lag: assert property (p_quad_lag)
    else $error("quadrature lag code decoded wrongly");

  property p_quad_lead;
    @(posedge clk) disable iff (sys_rst)
    value[15] == 1'b1 |=> cfg.quad_steps == (($past(value[14:13]) == 2'b00)
      ? -4'sh4 : $signed(4'h8 - {1'b0, $past(value[15:13])}));
  endproperty
  a_quad_lead: assert property (p_quad_lead)
    else $error("quadrature lead code decoded wrongly");

endmodule : shift_cfg_out

// file: rtl/postdiv_phase_shift_regs.sv
`timescale 1ns/1ns
`include "phase_shift_defines.svh"

// Summary of operation
// - Each coarse field is bits 12:0 of its pair, a two's complement count.
// - Coarse zero means no shift, negative delays and positive advances.
// - One pair steers every clock of its post divider together.
// - Bits 15:13 of a pair pick a quadrature shift in 45 degree steps.
// - Codes 000 to 011 give 0, -45, -90 and -135 degrees.
// - Codes 100 to 111 give 180, +135, +90 and +45 degrees.
// - Oscillator select bit 0 clear enables the oscillator driver.
// - The revision register reads the code alone; full_revision joins it with two outside bits.
module postdiv_phase_shift_regs #(
  // Revision code; the value is arbitrary.
  parameter logic [7:0] REVISION = 8'h5A,
  parameter int PAIRS = `SHIFT_PAIRS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [`BUS_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [`BUS_DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [`BUS_DATA_W-1:0] readdata,
  output logic waitrequest,
  // Revision bits held elsewhere
  input wire logic [1:0] rev_ext_bits,
  // Post divider settings
  output phase_shift_pkg::shift_cfg_s div_cfg [PAIRS],
  // Oscillator and revision
  output logic osc_out_driver_en,
  output logic [9:0] full_revision
);
  import phase_shift_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Maps a register index to a shift pair and its byte.
  function automatic slot_sel_s slot_of(input logic [7:0] idx);
    slot_of = '0;
    case (idx)
      `SYNTH0_DIVC_SHIFT_IDX: slot_of = '{1'b1, 1'b0, 3'h0};
      `SYNTH0_DIVC_SHIFT_IDX + 8'h01: slot_of = '{1'b1, 1'b1, 3'h0};
      `SYNTH0_DIVD_SHIFT_IDX: slot_of = '{1'b1, 1'b0, 3'h1};
      `SYNTH0_DIVD_SHIFT_IDX + 8'h01: slot_of = '{1'b1, 1'b1, 3'h1};
      `SYNTH1_DIVC_SHIFT_IDX: slot_of = '{1'b1, 1'b0, 3'h2};
      `SYNTH1_DIVC_SHIFT_IDX + 8'h01: slot_of = '{1'b1, 1'b1, 3'h2};
      `SYNTH1_DIVD_SHIFT_IDX: slot_of = '{1'b1, 1'b0, 3'h3};
      `SYNTH1_DIVD_SHIFT_IDX + 8'h01: slot_of = '{1'b1, 1'b1, 3'h3};
      `SYNTH2_DIVA_SHIFT_IDX: slot_of = '{1'b1, 1'b0, 3'h4};
      `SYNTH2_DIVA_SHIFT_IDX + 8'h01: slot_of = '{1'b1, 1'b1, 3'h4};
      default: slot_of = '0;
    endcase
  endfunction : slot_of

  logic [7:0] reg_idx;
  slot_sel_s sel;
  bus_state_e state;
  logic wr_fire;
  logic [7:0] osc_source_bit;
  logic [15:0] pair_value [PAIRS];
  logic [PAIRS-1:0] wr_lo;
  logic [PAIRS-1:0] wr_hi;
  logic [`BUS_DATA_W-1:0] next_readdata;

  assign reg_idx = address[9:2];
  assign sel = slot_of(reg_idx);

  // Writes land only at the edge where waitrequest is seen low.
  assign wr_fire = (state == BUS_ACK) && write && byteenable[0];

  // ****************************************************************
  // Bus handshake
  // ****************************************************************

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= BUS_IDLE;
    end else begin
      case (state)
        BUS_IDLE: begin
          if (read || write) begin
            state <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          state <= BUS_IDLE;
        end
        default: begin
          state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest drops for exactly the cycle after a request is seen.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((state == BUS_IDLE) && (read || write));
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  always_comb begin
    next_readdata = '0;
    if (sel.hit) begin
      for (int i = 0; i < PAIRS; i++) begin
        if (sel.slot == 3'(i)) begin
          next_readdata[7:0] = sel.hi ? pair_value[i][15:8]
                                      : pair_value[i][7:0];
        end
      end
    end else if (reg_idx == `OSC_SOURCE_SELECT_IDX) begin
      next_readdata[7:0] = osc_source_bit;
    end else if (reg_idx == `SILICON_REVISION_IDX) begin
      next_readdata[7:0] = REVISION;
    end
  end

  // Read data are held from the ack cycle until the next read.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readdata <= '0;
    end else if ((state == BUS_IDLE) && read) begin
      readdata <= next_readdata;
    end
  end

  // ****************************************************************
  // Shift register pairs
  // ****************************************************************

  genvar g;
  generate
    for (g = 0; g < PAIRS; g++) begin : g_pair
      assign wr_lo[g] = wr_fire && sel.hit && !sel.hi && sel.slot == 3'(g);
      assign wr_hi[g] = wr_fire && sel.hit && sel.hi && sel.slot == 3'(g);

      shift_pair_reg u_pair (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_lo(wr_lo[g]),
        .wr_hi(wr_hi[g]),
        .wr_byte(writedata[7:0]),
        .value(pair_value[g])
      );

      // One setting feeds the whole post divider, never one pin.
      shift_cfg_out u_cfg (
        .clk(clk),
        .sys_rst(sys_rst),
        .value(pair_value[g]),
        .cfg(div_cfg[g])
      );

      property p_pair_to_divider;
        @(posedge clk) disable iff (sys_rst)
        wr_hi[g] |=> ##1 div_cfg[g].coarse == pair_value[g][12:0]
          && div_cfg[g].quad_code == pair_value[g][15:13];
      endproperty
      a_pair_to_divider: assert property (p_pair_to_divider)
        else $error("divider settings do not follow their pair");

      property p_coarse_sign;
        @(posedge clk) disable iff (sys_rst)
        wr_hi[g] |=> ##1
          ($signed(div_cfg[g].coarse) < 0) == pair_value[g][12];
      endproperty
      a_coarse_sign: assert property (p_coarse_sign)
        else $error("coarse shift sign does not follow bit twelve");
    end
  endgenerate

  // ****************************************************************
  // Oscillator source and revision
  // ****************************************************************

  // Reserved bits 7:1 are not stored and read as zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_source_bit <= `OSC_SOURCE_RESET;
    end else if (wr_fire && reg_idx == `OSC_SOURCE_SELECT_IDX) begin
      osc_source_bit <= {7'h00, writedata[`OSC_SOURCE_BIT]};
    end
  end

  // Driver runs while the bit is clear, as for a crystal.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_out_driver_en <= 1'b1;
    end else if (wr_fire && reg_idx == `OSC_SOURCE_SELECT_IDX) begin
      osc_out_driver_en <= !writedata[`OSC_SOURCE_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_revision <= 10'h000;
    end else begin
      full_revision <= {rev_ext_bits, REVISION};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_ack_after_request;
    @(posedge clk) disable iff (sys_rst)
    (state == BUS_IDLE) && (read || write) |=> !waitrequest ##1 waitrequest;
  endproperty
  a_ack_after_request: assert property (p_ack_after_request)
    else $error("waitrequest not low for exactly one cycle");

  property p_osc_driver;
    @(posedge clk) disable iff (sys_rst)
    wr_fire && reg_idx == `OSC_SOURCE_SELECT_IDX |=>
      osc_out_driver_en == !$past(writedata[0])
      && osc_source_bit[0] == $past(writedata[0]);
  endproperty
  a_osc_driver: assert property (p_osc_driver)
    else $error("oscillator driver does not follow select bit");

  property p_osc_hold;
    @(posedge clk) disable iff (sys_rst)
    !(wr_fire && reg_idx == `OSC_SOURCE_SELECT_IDX) |=>
      $stable(osc_out_driver_en) && osc_out_driver_en == !osc_source_bit[0];
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("oscillator driver changed without a write");

  property p_revision_read;
    @(posedge clk) disable iff (sys_rst)
    (state == BUS_IDLE) && read && reg_idx == `SILICON_REVISION_IDX |=>
      !waitrequest && readdata == {24'h000000, REVISION};
  endproperty
  a_revision_read: assert property (p_revision_read)
    else $error("revision read returned the wrong code");

  property p_full_revision;
    @(posedge clk) disable iff (sys_rst)
    !sys_rst |=> full_revision == {$past(rev_ext_bits), REVISION};
  endproperty
  a_full_revision: assert property (p_full_revision)
    else $error("full revision not formed from both parts");

  // Slot of the last low byte write, so the check sees the right divider.
  logic [2:0] lo_slot;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_slot <= 3'h0;
    end else if (wr_fire && sel.hit && !sel.hi) begin
      lo_slot <= sel.slot;
    end
  end

  property p_lo_write_no_effect;
    @(posedge clk) disable iff (sys_rst)
    wr_fire && sel.hit && !sel.hi |=> ##1 $stable(div_cfg[lo_slot]);
  endproperty
  a_lo_write_no_effect: assert property (p_lo_write_no_effect)
    else $error("low byte write changed a divider setting");

  property p_onehot_strobe;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |-> $onehot0({wr_hi, wr_lo});
  endproperty
  a_onehot_strobe: assert property (p_onehot_strobe)
    else $error("one write reached more than one pair byte");

  property p_wait_single;
    @(posedge clk) disable iff (sys_rst)
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single)
    else $error("waitrequest stayed low for a second cycle");

  property p_wait_idle;
    @(posedge clk) disable iff (sys_rst)
    (state == BUS_IDLE) && !read && !write |=> waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest dropped with no request");

  property p_readdata_hold;
    @(posedge clk) disable iff (sys_rst)
    !((state == BUS_IDLE) && read) |=> $stable(readdata);
  endproperty
  a_readdata_hold: assert property (p_readdata_hold)
    else $error("read data changed without a new read");

  property p_read_upper_zero;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |-> readdata[31:8] == 24'h000000;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero)
    else $error("upper read data bits are not zero");

  property p_unmapped_read;
    @(posedge clk) disable iff (sys_rst)
    (state == BUS_IDLE) && read && !sel.hit
      && reg_idx != `OSC_SOURCE_SELECT_IDX
      && reg_idx != `SILICON_REVISION_IDX |=> readdata == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped register did not read as zero");

  property p_be_ignored;
    @(posedge clk) disable iff (sys_rst)
    (state == BUS_ACK) && write && !byteenable[0] |=>
      $stable(osc_source_bit) && $stable(osc_out_driver_en);
  endproperty
  a_be_ignored: assert property (p_be_ignored)
    else $error("write without its low byte lane changed a register");

  property p_osc_reserved;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |-> osc_source_bit[7:1] == 7'h00;
  endproperty
  a_osc_reserved: assert property (p_osc_reserved)
    else $error("reserved oscillator select bits are not zero");

  property p_osc_read;
    @(posedge clk) disable iff (sys_rst)
    (state == BUS_IDLE) && read && reg_idx == `OSC_SOURCE_SELECT_IDX |=>
      readdata == {31'h00000000, !$past(osc_out_driver_en)};
  endproperty
  a_osc_read: assert property (p_osc_read)
    else $error("oscillator select read back does not match the driver");

  property p_revision_write;
    @(posedge clk) disable iff (sys_rst)
    wr_fire && reg_idx == `SILICON_REVISION_IDX |=>
      $stable(osc_source_bit) && $stable(osc_out_driver_en);
  endproperty
  a_revision_write: assert property (p_revision_write)
    else $error("write to the revision register changed a setting");

endmodule : postdiv_phase_shift_regs

// file: sim/postdiv_phase_shift_regs_tb.sv
`timescale 1ns/1ns
`include "phase_shift_defines.svh"

module postdiv_phase_shift_regs_tb;
  import phase_shift_pkg::*;
  // The value is arbitrary.
  localparam logic [7:0] REV = 8'h96;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] rev_ext_bits = 2'h1;
  shift_cfg_s div_cfg [`SHIFT_PAIRS];
  logic osc_out_driver_en;
  logic [9:0] full_revision;
  logic [15:0] model [5];
  logic [7:0] staged [5];
  logic [7:0] idx_tab [5];
  logic [12:0] corner [8];
  logic osc_exp;
  logic [31:0] rd;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  postdiv_phase_shift_regs #(.REVISION(REV), .PAIRS(`SHIFT_PAIRS)) dut (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .rev_ext_bits(rev_ext_bits), .div_cfg(div_cfg),
    .osc_out_driver_en(osc_out_driver_en), .full_revision(full_revision)
  );

  always #50 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic final_report();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  function automatic shift_cfg_s exp_cfg(logic [15:0] v);
    shift_cfg_s c;
    c.coarse = v[12:0];
    c.quad_code = v[15:13];
    case (v[15:13])
      3'h0: c.quad_steps = 4'h0;
      3'h1: c.quad_steps = 4'hF;
      3'h2: c.quad_steps = 4'hE;
      3'h3: c.quad_steps = 4'hD;
      3'h4: c.quad_steps = 4'hC;
      3'h5: c.quad_steps = 4'h3;
      3'h6: c.quad_steps = 4'h2;
      default: c.quad_steps = 4'h1;
    endcase
    return c;
  endfunction : exp_cfg

  task automatic bus_write(logic [7:0] idx, logic [7:0] d, logic [3:0] be);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {~d, ~d, ~d, d};
    byteenable <= be;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(logic [7:0] idx, output logic [31:0] d);
    @(posedge clk);
    address <= {idx, 2'b00};
    byteenable <= 4'($urandom);
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_read

  task automatic write_pair(int s, logic [15:0] v);
    bus_write(idx_tab[s], v[7:0], 4'h1);
    staged[s] = v[7:0];
    bus_write(idx_tab[s] + 8'h01, v[15:8], 4'hF);
    model[s] = v;
  endtask : write_pair

  task automatic check_slots();
    logic [31:0] v;
    repeat (2) @(negedge clk);
    check("osc_out_driver_en", 32'(osc_out_driver_en), 32'(osc_exp));
    for (int i = 0; i < 5; i++) begin
      check("div_cfg", 32'(div_cfg[i]), 32'(exp_cfg(model[i])));
      bus_read(idx_tab[i], v);
      check("pair_lo", v, {24'h0, model[i][7:0]});
      bus_read(idx_tab[i] + 8'h01, v);
      check("pair_hi", v, {24'h0, model[i][15:8]});
    end
  endtask : check_slots

  task automatic clear_model();
    for (int i = 0; i < 5; i++) begin
      model[i] = 16'h0000;
      staged[i] = 8'h00;
    end
    osc_exp = 1'b1;
  endtask : clear_model

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    idx_tab = '{`SYNTH0_DIVC_SHIFT_IDX, `SYNTH0_DIVD_SHIFT_IDX,
      `SYNTH1_DIVC_SHIFT_IDX, `SYNTH1_DIVD_SHIFT_IDX, `SYNTH2_DIVA_SHIFT_IDX};
    corner = '{13'h0000, 13'h0001, 13'h1FFF, 13'h0FFF, 13'h1000, 13'h1555,
      13'h0AAA, 13'h1FFE};
    clear_model();
    void'($urandom(32'hB871));
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("waitrequest", 32'(waitrequest), 32'h1);
    check("full_revision", 32'(full_revision), 32'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    check_slots();
    check("full_revision", 32'(full_revision), {22'h0, 2'h1, REV});
    bus_read(`OSC_SOURCE_SELECT_IDX, rd);
    check("osc_source_select", rd, 32'h0);
    $display("test reset done");

    for (int q = 0; q < 8; q++) begin
      write_pair(q % 5, {q[2:0], corner[q]});
      check_slots();
    end
    $display("test quadrature done");

    bus_write(idx_tab[2], 8'h3C, 4'h1);
    staged[2] = 8'h3C;
    check_slots();
    bus_write(idx_tab[2] + 8'h01, 8'hA5, 4'hE);
    check_slots();
    bus_write(idx_tab[2] + 8'h01, 8'hA5, 4'h1);
    model[2] = {8'hA5, staged[2]};
    check_slots();
    $display("test atomic done");

    bus_write(`OSC_SOURCE_SELECT_IDX, 8'hFF, 4'h1);
    osc_exp = 1'b0;
    check_slots();
    bus_read(`OSC_SOURCE_SELECT_IDX, rd);
    check("osc_source_select", rd, 32'h1);
    bus_write(`OSC_SOURCE_SELECT_IDX, 8'h00, 4'hE);
    check_slots();
    bus_write(`OSC_SOURCE_SELECT_IDX, 8'h00, 4'h1);
    osc_exp = 1'b1;
    check_slots();
    $display("test oscillator done");

    bus_write(`SILICON_REVISION_IDX, 8'h00, 4'hF);
    bus_read(`SILICON_REVISION_IDX, rd);
    check("silicon_revision", rd, {24'h0, REV});
    rev_ext_bits <= 2'h2;
    repeat (2) @(negedge clk);
    check("full_revision", 32'(full_revision), {22'h0, 2'h2, REV});
    bus_write(8'h10, 8'h77, 4'hF);
    bus_read(8'h10, rd);
    check("unmapped", rd, 32'h0);
    check_slots();
    $display("test revision done");

    for (int n = 0; n < 40; n++) begin
      write_pair($urandom % 5, 16'($urandom));
      check_slots();
    end
    $display("test random done");

    @(posedge clk);
    sys_rst <= 1'b1;
    @(negedge clk);
    check("waitrequest", 32'(waitrequest), 32'h1);
    @(posedge clk);
    sys_rst <= 1'b0;
    clear_model();
    check_slots();
    write_pair(4, 16'h9FFF);
    check_slots();
    $display("test second reset done");
    final_report();
  end

endmodule : postdiv_phase_shift_regs_tb
